// *** rtl/axis_counter_pkg.sv ***
`default_nettype none
package axis_counter_pkg;
  // Counter geometry
  localparam int CNT_W = 32;
  localparam int NUM_CNT = 3;
  localparam int NUM_CH = 3;
  localparam int PRE_W = 8;
  // Counter indices
  localparam logic [1:0] CNT_ADDRESS = 2'h0;
  localparam logic [1:0] CNT_DIFF = 2'h1;
  localparam logic [1:0] CNT_SPEED = 2'h2;
  // Encoder multiplier codes
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_X4 = 2'h2;
  // Reset values
  localparam logic [31:0] CMP_RESET = 32'h8000_0000;
  localparam logic [31:0] SPEED_CMP_RESET = 32'h0000_0000;
  localparam logic [31:0] MAX_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [1:0] MULT_RESET = MULT_X1;
  localparam logic [7:0] PRESCALE_RESET = 8'h01;
  localparam logic [2:0] GATE_EN_RESET = 3'h7;
  localparam logic [2:0] STOP_EN_RESET = 3'h0;
  localparam logic [2:0] INT_EN_RESET = 3'h0;
  localparam logic ABS_DIFF_RESET = 1'b1;
  localparam logic INT_PULSE_RESET = 1'b0;
  localparam logic CLEAR_EN_RESET = 1'b0;
  localparam logic RELOAD_EN_RESET = 1'b0;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int INT_PULSE_NS = 200;
  localparam int INT_PULSE_CYC_I = INT_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [2:0] INT_PULSE_CYC =
    (INT_PULSE_CYC_I < 1) ? 3'h1 : 3'(INT_PULSE_CYC_I);
endpackage : axis_counter_pkg
`default_nettype wire

// *** rtl/axis_counter_compare.sv ***
`timescale 1ns/1ns
`default_nettype none
module axis_counter_compare
  import axis_counter_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  // Own axis pulse output and direction (1 = plus)
  input wire logic out_pulse,
  input wire logic out_dir,
  // Encoder inputs
  input wire logic encoder_phase_a,
  input wire logic encoder_phase_b,
  // Configuration write
  input wire logic cfg_we,
  input wire logic [1:0] cfg_mult,
  input wire logic [7:0] cfg_prescale,
  input wire logic cfg_int_pulse,
  input wire logic cfg_abs_diff,
  input wire logic [2:0] cfg_gate_en,
  input wire logic [2:0] cfg_stop_en,
  input wire logic [2:0] cfg_int_en,
  input wire logic cfg_clear_en,
  input wire logic cfg_reload_en,
  // Compare register write
  input wire logic cmp_we,
  input wire logic [1:0] cmp_counter,
  input wire logic [1:0] cmp_channel,
  input wire logic [31:0] cmp_value,
  // Max count write
  input wire logic max_we,
  input wire logic [1:0] max_counter,
  input wire logic [31:0] max_value,
  // Preset write, also loads the counter
  input wire logic preset_we,
  input wire logic [1:0] preset_counter,
  input wire logic [31:0] preset_value,
  // Sticky flag clears
  input wire logic int_clear,
  input wire logic [2:0] ovf_clear,
  // Outputs
  output logic [31:0] address_count,
  output logic [31:0] position_difference_counter,
  output logic [31:0] speed_count,
  output logic [2:0] channel_match,
  output logic compare_gate,
  output logic stop_request,
  output logic match_int,
  output logic [2:0] overflow
);

  // Signed step of -2..+2 encoded in three bits
  typedef logic signed [2:0] step_t;

  // Quadrature decode at the selected multiplier
  function automatic step_t quad_step(
    input logic ap, input logic bp, input logic a, input logic b,
    input logic [1:0] mult);
    logic fwd;
    logic a_edge;
    logic b_edge;
    step_t s;
    fwd = a ^ bp;
    a_edge = a ^ ap;
    b_edge = b ^ bp;
    s = 3'sd0;
    case (mult)
      // Both edges of A
      MULT_X2: begin
        if (a_edge) s = (a != b) ? 3'sd1 : -3'sd1;
      end
      // Every edge of A or B
      MULT_X4: begin
        if (a_edge ^ b_edge) s = fwd ? 3'sd1 : -3'sd1;
      end
      default: begin
        if (a_edge && a) s = b ? -3'sd1 : 3'sd1;
      end
    endcase
    return s;
  endfunction : quad_step

  // Absolute value of a two's complement count
  function automatic logic [31:0] abs32(input logic [31:0] v);
    return v[31] ? 32'(~v + 32'h0000_0001) : v;
  endfunction : abs32

  // Configuration state
  logic [1:0] mult;
  logic [7:0] prescale;
  logic int_pulse_mode;
  logic abs_diff;
  logic [2:0] gate_en;
  logic [2:0] stop_en;
  logic [2:0] int_en;
  logic clear_en;
  logic reload_en;

  // Per counter storage
  logic [31:0] cnt [NUM_CNT];
  logic [31:0] cmp [NUM_CNT][NUM_CH];
  logic [31:0] max_cnt [NUM_CNT];
  logic [31:0] preset [NUM_CNT];
  logic [7:0] pre_cnt [NUM_CNT];

  // Previous encoder levels
  logic enc_a_prev;
  logic enc_b_prev;

  // Decoded steps
  step_t enc_step;
  step_t own_step;
  step_t step [NUM_CNT];

  // Match matrix and channel summaries
  logic match [NUM_CNT][NUM_CH];
  logic [2:0] next_chan;
  logic [2:0] chan_prev;
  logic [2:0] int_pulse_cnt;

  // Configuration register, defaults at reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mult <= MULT_RESET;
      prescale <= PRESCALE_RESET;
      int_pulse_mode <= INT_PULSE_RESET;
      abs_diff <= ABS_DIFF_RESET;
      gate_en <= GATE_EN_RESET;
      stop_en <= STOP_EN_RESET;
      int_en <= INT_EN_RESET;
      clear_en <= CLEAR_EN_RESET;
      reload_en <= RELOAD_EN_RESET;
    end else if (cfg_we) begin
      mult <= cfg_mult;
      prescale <= cfg_prescale;
      int_pulse_mode <= cfg_int_pulse;
      abs_diff <= cfg_abs_diff;
      gate_en <= cfg_gate_en;
      stop_en <= cfg_stop_en;
      int_en <= cfg_int_en;
      clear_en <= cfg_clear_en;
      reload_en <= cfg_reload_en;
    end
  end

  // Compare, max and preset registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NUM_CNT; c++) begin
        for (int k = 0; k < NUM_CH; k++) begin
          // Speed counter keeps its own default
          cmp[c][k] <= (c == int'(CNT_SPEED)) ?
            SPEED_CMP_RESET : CMP_RESET;
        end
        max_cnt[c] <= MAX_RESET;
        preset[c] <= PRESET_RESET;
      end
    end else begin
      if (cmp_we && cmp_counter < 2'h3 && cmp_channel < 2'h3) begin
        cmp[cmp_counter][cmp_channel] <= cmp_value;
      end
      if (max_we && max_counter < 2'h3) begin
        max_cnt[max_counter] <= max_value;
      end
      if (preset_we && preset_counter < 2'h3) begin
        preset[preset_counter] <= preset_value;
      end
    end
  end

  // Encoder level history
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enc_a_prev <= 1'b0;
      enc_b_prev <= 1'b0;
    end else begin
      enc_a_prev <= encoder_phase_a;
      enc_b_prev <= encoder_phase_b;
    end
  end

  // Count sources of each counter
  always_comb begin
    enc_step = quad_step(enc_a_prev, enc_b_prev, encoder_phase_a,
      encoder_phase_b, mult);
    own_step = out_pulse ? (out_dir ? 3'sd1 : -3'sd1) : 3'sd0;
    step[CNT_ADDRESS] = own_step;
    // Commanded minus fed-back position
    step[CNT_DIFF] = step_t'(own_step - enc_step);
    step[CNT_SPEED] = enc_step;
  end

  // Compare logic per counter and channel
  always_comb begin
    for (int c = 0; c < NUM_CNT; c++) begin
      for (int k = 0; k < NUM_CH; k++) begin
        if (c == int'(CNT_DIFF) && abs_diff) begin
          // Magnitude of the position gap
          case (k)
            1: match[c][k] = abs32(cnt[c]) >= cmp[c][k];
            2: match[c][k] = abs32(cnt[c]) <= cmp[c][k];
            default: match[c][k] = abs32(cnt[c]) == cmp[c][k];
          endcase
        end else begin
          match[c][k] = cnt[c] == cmp[c][k];
        end
      end
    end
    for (int k = 0; k < NUM_CH; k++) begin
      next_chan[k] = match[0][k] | match[1][k] | match[2][k];
    end
  end

  // Counters with prescale, wrap, auto clear and reload
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NUM_CNT; c++) begin
        cnt[c] <= PRESET_RESET;
        pre_cnt[c] <= 8'h00;
      end
      overflow <= 3'h0;
    end else begin
      for (int c = 0; c < NUM_CNT; c++) begin
        // Software clear; a new overflow below wins
        if (ovf_clear[c]) overflow[c] <= 1'b0;
        if (preset_we && preset_counter == 2'(c)) begin
          cnt[c] <= preset_value;
          pre_cnt[c] <= 8'h00;
        end else if (match[c][0] && clear_en) begin
          cnt[c] <= 32'h0000_0000;
        end else if (match[c][0] && reload_en) begin
          cnt[c] <= preset[c];
        end else if (step[c] != 3'sd0) begin
          // Divide count pulses by the prescale ratio
          if (pre_cnt[c] + 8'h01 >= prescale) begin
            pre_cnt[c] <= 8'h00;
            if (step[c] > 3'sd0) begin
              if (cnt[c] == max_cnt[c]) begin
                cnt[c] <= 32'h0000_0000;
                overflow[c] <= 1'b1;
              end else begin
                cnt[c] <= 32'(cnt[c] + 32'(step[c]));
              end
            end else begin
              if (cnt[c] == 32'h0000_0000 && c != int'(CNT_DIFF)) begin
                // Underflow wraps to the limit
                cnt[c] <= max_cnt[c];
                overflow[c] <= 1'b1;
              end else begin
                cnt[c] <= 32'(cnt[c] + 32'(step[c]));
              end
            end
          end else begin
            pre_cnt[c] <= 8'(pre_cnt[c] + 8'h01);
          end
        end
      end
    end
  end

  // Registered counter views
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      address_count <= 32'h0000_0000;
      position_difference_counter <= 32'h0000_0000;
      speed_count <= 32'h0000_0000;
    end else begin
      address_count <= cnt[CNT_ADDRESS];
      position_difference_counter <= cnt[CNT_DIFF];
      speed_count <= cnt[CNT_SPEED];
    end
  end

  // Match, gate and stop outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      channel_match <= 3'h0;
      chan_prev <= 3'h0;
      compare_gate <= 1'b0;
      stop_request <= 1'b0;
    end else begin
      channel_match <= next_chan;
      chan_prev <= next_chan;
      compare_gate <= |(next_chan & gate_en);
      // Immediate stop while an enabled channel matches
      stop_request <= |(next_chan & stop_en);
    end
  end

  // Match interrupt: latched level or fixed width pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      match_int <= 1'b0;
      int_pulse_cnt <= 3'h0;
    end else begin
      if (|(next_chan & ~chan_prev & int_en)) begin
        if (int_pulse_mode) begin
          match_int <= 1'b1;
          int_pulse_cnt <= INT_PULSE_CYC;
        end else begin
          // Set wins over a same cycle clear
          match_int <= 1'b1;
        end
      end else if (int_pulse_mode) begin
        if (int_pulse_cnt > 3'h1) begin
          int_pulse_cnt <= 3'(int_pulse_cnt - 3'h1);
        end else begin
          int_pulse_cnt <= 3'h0;
          match_int <= 1'b0;
        end
      end else if (int_clear) begin
        match_int <= 1'b0;
      end
    end
  end

endmodule : axis_counter_compare
`default_nettype wire

// *** tb/quad_encoder_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module quad_encoder_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic step,
  input wire logic back,
  output logic phase_a,
  output logic phase_b
);
  // Quarter position within the quadrature cycle
  logic [1:0] pos;
  // One quarter per strobe, retreating when back is high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pos <= 2'h0;
    end else if (step) begin
      pos <= back ? pos - 2'h1 : pos + 2'h1;
    end
  end
  // Gray pattern, A leads B going forward
  assign phase_a = pos[1] ^ pos[0];
  assign phase_b = pos[1];
endmodule : quad_encoder_model
`default_nettype wire

// *** tb/axis_counter_compare_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module axis_counter_compare_asserts
  import axis_counter_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic out_dir,
  input wire logic out_pulse,
  input wire logic cfg_we,
  input wire logic cfg_int_pulse,
  input wire logic [2:0] cfg_gate_en,
  input wire logic [2:0] cfg_stop_en,
  input wire logic [2:0] cfg_int_en,
  input wire logic preset_we,
  input wire logic int_clear,
  input wire logic [2:0] ovf_clear,
  input wire logic [31:0] address_count,
  input wire logic [2:0] channel_match,
  input wire logic compare_gate,
  input wire logic stop_request,
  input wire logic match_int,
  input wire logic [2:0] overflow
);
  // Mirror of the enables the outputs depend on
  logic [2:0] gate_q;
  logic [2:0] stop_q;
  logic [2:0] int_q;
  logic pulse_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_q <= GATE_EN_RESET;
      stop_q <= STOP_EN_RESET;
      int_q <= INT_EN_RESET;
      pulse_q <= INT_PULSE_RESET;
    end else if (cfg_we) begin
      gate_q <= cfg_gate_en;
      stop_q <= cfg_stop_en;
      int_q <= cfg_int_en;
      pulse_q <= cfg_int_pulse;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_gate_or: assert property (
    compare_gate == |(channel_match & $past(gate_q)))
    else $error("gate output differs from enabled matches");
  a_stop_or: assert property (
    stop_request == |(channel_match & $past(stop_q)))
    else $error("stop request differs from enabled matches");
  a_addr_own: assert property (out_pulse && !preset_we |=> ##1
    address_count == $past(address_count) + ($past(out_dir, 2) ?
    32'h0000_0001 : 32'hFFFF_FFFF)) else $error("address step wrong");
  a_ovf_sticky: assert property (1'b1 |=>
    ($past(overflow & ~ovf_clear) & ~overflow) == 3'h0)
    else $error("overflow flag dropped without clear");
  a_int_quiet: assert property (!match_int && int_q == 3'h0 &&
    $past(int_q) == 3'h0 |=> !match_int) else $error("masked interrupt");
  a_int_latch: assert property (match_int && !int_clear && !pulse_q &&
    !$past(pulse_q) |=> match_int) else $error("latched interrupt lost");
  a_int_pulse: assert property ($rose(match_int) && pulse_q &&
    $past(pulse_q) |=> match_int ##1 !match_int)
    else $error("through interrupt not two cycles");
  a_reset_zero: assert property ($rose(rstn) |-> address_count ==
    32'h0000_0000 && overflow == 3'h0 && !match_int)
    else $error("outputs not cleared by reset");
endmodule : axis_counter_compare_asserts
bind axis_counter_compare axis_counter_compare_asserts u_asserts (
  .ref_clk, .rstn, .out_dir, .out_pulse, .cfg_we, .cfg_int_pulse,
  .cfg_gate_en, .cfg_stop_en, .cfg_int_en, .preset_we, .int_clear,
  .ovf_clear, .address_count, .channel_match, .compare_gate,
  .stop_request, .match_int, .overflow
);
`default_nettype wire

// *** tb/axis_counter_compare_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module axis_counter_compare_tb;
  import axis_counter_pkg::*;
  // Stimulus, driven at the falling edge
  logic ref_clk = 1'b0, rstn = 1'b0, out_pulse = 1'b0, out_dir = 1'b0;
  logic step = 1'b0, back = 1'b0, cfg_we = 1'b0, cfg_int_pulse = 1'b0;
  logic cmp_we = 1'b0, preset_we = 1'b0, int_clear = 1'b0;
  logic cfg_abs_diff = ABS_DIFF_RESET, cfg_clear_en = CLEAR_EN_RESET;
  logic cfg_reload_en = RELOAD_EN_RESET;
  logic [1:0] cfg_mult = MULT_RESET;
  logic [7:0] cfg_prescale = PRESCALE_RESET;
  logic [2:0] cfg_gate_en = 3'h7, cfg_stop_en = 3'h0, cfg_int_en = 3'h0;
  logic [2:0] ovf_clear = 3'h0;
  logic [1:0] cmp_counter = 2'h0, cmp_channel = 2'h0, preset_counter = 2'h0;
  logic [31:0] cmp_value = 32'h0000_0000, preset_value = 32'h0000_0000;
  // Observed side
  wire logic encoder_phase_a, encoder_phase_b, compare_gate, stop_request;
  wire logic match_int;
  wire logic [31:0] address_count, position_difference_counter, speed_count;
  wire logic [2:0] channel_match, overflow;
  // Status word: overflow, stop, interrupt, gate, matches
  wire logic [8:0] st = {overflow, stop_request, match_int, compare_gate,
                         channel_match};
  int failures = 0, check_count = 0;
  // Overflow limits stay at reset
  axis_counter_compare u_dut (
    .ref_clk, .rstn, .out_pulse, .out_dir, .encoder_phase_a,
    .encoder_phase_b, .cfg_we, .cfg_mult, .cfg_prescale, .cfg_int_pulse,
    .cfg_abs_diff, .cfg_gate_en, .cfg_stop_en, .cfg_int_en, .cfg_clear_en,
    .cfg_reload_en, .cmp_we, .cmp_counter, .cmp_channel, .cmp_value,
    .max_we(1'b0), .max_counter(2'h0), .max_value(32'h0000_0000),
    .preset_we, .preset_counter, .preset_value, .int_clear, .ovf_clear,
    .address_count, .position_difference_counter, .speed_count,
    .channel_match, .compare_gate, .stop_request, .match_int, .overflow
  );
  // Encoder on the far side
  quad_encoder_model u_enc (.ref_clk, .rstn, .step, .back,
    .phase_a(encoder_phase_a), .phase_b(encoder_phase_b));
  // 10 MHz clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // Own pulse, then n settle cycles
  task automatic pulse(input logic dir, input int n);
    @(negedge ref_clk);
    out_pulse = 1'b1;
    out_dir = dir;
    @(negedge ref_clk);
    out_pulse = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask : pulse
  // Compare write when sel low, preset (loads counter) when high
  task automatic put(input logic sel, input logic [1:0] ctr,
                     input logic [1:0] ch, input logic [31:0] v);
    @(negedge ref_clk);
    // Host writes only between own pulses, axis idle
    {cmp_we, preset_we} = {!sel, sel};
    {cmp_counter, preset_counter, cmp_channel} = {ctr, ctr, ch};
    {cmp_value, preset_value} = {v, v};
    @(negedge ref_clk);
    {cmp_we, preset_we} = 2'b00;
    repeat (3) @(negedge ref_clk);
  endtask : put
  // Configuration write, other fields from the cfg_ signals as they stand
  task automatic cfg(input logic [2:0] stop, input logic [2:0] ien,
                     input logic pls);
    @(negedge ref_clk);
    // Settings change only while no own pulse is out
    {cfg_we, cfg_stop_en, cfg_int_en, cfg_int_pulse} =
      {1'b1, stop, ien, pls};
    @(negedge ref_clk);
    cfg_we = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : cfg
  // Hang guard
  initial begin
    #100_000;
    failures++;
    conclude();
  end
  initial begin
    int hi;
    hi = 0;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(32'(st), 32'h0000_000F);
    repeat (5) pulse(1'b1, 3);
    chk(address_count, 32'h0000_0005);
    chk(position_difference_counter, 32'h0000_0005);
    repeat (8) begin
      @(negedge ref_clk) step = 1'b1;
      @(negedge ref_clk) step = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    chk(speed_count, 32'h0000_0002);
    chk(position_difference_counter, 32'h0000_0003);
    chk(32'(st), 32'h0000_000C);
    put(1'b0, CNT_DIFF, 2'h1, 32'h0000_0003);
    put(1'b0, CNT_DIFF, 2'h2, 32'h0000_0003);
    chk(32'(st), 32'h0000_000E);
    put(1'b1, CNT_DIFF, 2'h0, 32'hFFFF_FFFD);
    chk(32'(st), 32'h0000_000E);
    put(1'b1, CNT_DIFF, 2'h0, 32'hFFFF_FFFC);
    chk(32'(st), 32'h0000_000A);
    put(1'b1, CNT_ADDRESS, 2'h0, 32'h7FFF_FFFF);
    chk(32'(st), 32'h0000_000A);
    pulse(1'b1, 8);
    chk(32'(st), 32'h0000_000F);
    chk(address_count, 32'h8000_0000);
    cfg(3'h1, 3'h1, 1'b0);
    chk(32'(st), 32'h0000_002F);
    pulse(1'b0, 3);
    chk(32'(st), 32'h0000_000A);
    pulse(1'b1, 4);
    chk(32'(st), 32'h0000_003F);
    pulse(1'b0, 3);
    chk(32'(st), 32'h0000_001A);
    @(negedge ref_clk) int_clear = 1'b1;
    @(negedge ref_clk) int_clear = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(32'(st), 32'h0000_000A);
    cfg(3'h0, 3'h1, 1'b1);
    pulse(1'b1, 0);
    repeat (8) begin
      @(negedge ref_clk);
      hi += (match_int === 1'b1);
    end
    chk(hi, 32'h0000_0002);
    put(1'b1, CNT_ADDRESS, 2'h0, 32'hFFFF_FFFF);
    pulse(1'b1, 3);
    chk(address_count, 32'h0000_0000);
    chk(32'(overflow), 32'h0000_0001);
    pulse(1'b0, 3);
    chk(address_count, 32'hFFFF_FFFF);
    @(negedge ref_clk) ovf_clear = 3'h1;
    @(negedge ref_clk) ovf_clear = 3'h0;
    repeat (3) @(negedge ref_clk);
    chk(32'(overflow), 32'h0000_0000);
    // Encoder turned back one cycle: speed down, gap up
    back = 1'b1;
    repeat (4) begin
      @(negedge ref_clk) step = 1'b1;
      @(negedge ref_clk) step = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    chk(speed_count, 32'h0000_0001);
    chk(position_difference_counter, 32'hFFFF_FFFE);
    // Times four decode, every second count pulse advances
    cfg_mult = MULT_X4;
    cfg_prescale = 8'h02;
    back = 1'b0;
    cfg(3'h0, 3'h1, 1'b1);
    repeat (4) begin
      @(negedge ref_clk) step = 1'b1;
      @(negedge ref_clk) step = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
    chk(speed_count, 32'h0000_0003);
    chk(position_difference_counter, 32'hFFFF_FFFC);
    conclude();
  end
endmodule : axis_counter_compare_tb
`default_nettype wire
